// File: core/dasm_monitor.sv
// Dual axis standstill, speed and direction monitor with AHB-Lite registers.
// Assumes all pulse inputs are already synchronous to CORE_CLK.
//
// Implementation choices: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
module dasm_monitor #(
  parameter int unsigned TICK_CYC = dasm_pkg::TICK_CYC // Cycles per time base tick.
) (
  input  wire logic                CORE_CLK,
  input  wire logic                RST,
  input  wire dasm_pkg::dasm_enc_t ENCODER_PORT_AXIS_ONE,
  input  wire dasm_pkg::dasm_enc_t ENCODER_PORT_AXIS_TWO,
  input  wire logic                PROX_IN_AXIS_ONE_FIRST,
  input  wire logic                PROX_IN_AXIS_ONE_SECOND,
  input  wire logic                PROX_IN_AXIS_TWO_FIRST,
  input  wire logic                PROX_IN_AXIS_TWO_SECOND,
  output dasm_pkg::dasm_axis_t     AXIS_ONE_STATUS,
  output dasm_pkg::dasm_axis_t     AXIS_TWO_STATUS,
  input  wire logic                HSEL,
  input  wire logic [31:0]         HADDR,
  input  wire logic [1:0]          HTRANS,
  input  wire logic                HWRITE,
  input  wire logic [2:0]          HSIZE,
  input  wire logic [31:0]         HWDATA,
  input  wire logic                HREADY,
  output logic                     HREADYOUT,
  output logic                     HRESP,
  output logic [31:0]              HRDATA
);
  import dasm_pkg::*;

  // All checks run on the core clock and rest while reset is asserted.
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (RST);

  dasm_state_t              st;      // Registered state.
  dasm_state_t              nx;      // Next state.
  logic [NAX*NSIG-1:0]      sig;     // All pulse inputs, axis-major.
  logic [NAX*NSIG-1:0]      rise;    // Rising edge per input.
  logic                     tick;    // One-cycle time base enable.
  logic                     gate_end; // Last tick of a gate window.
  logic                     addr_ok; // Address phase of a valid transfer.
  logic [NAX-1:0]           still_c; // Standstill by measurement.
  logic [NAX-1:0]           diff_c;  // Pair mismatch or bad arrangement.
  logic [NAX-1:0]           shear_c; // Broken shearpin seen.
  logic [NAX-1:0]           ovs_c;   // Any used signal above the limit.
  logic [NAX-1:0]           safe_c;  // Fault forcing the safe state.

  // Encoder connector one feeds axis one, connector two feeds axis two.
  assign sig = {PROX_IN_AXIS_TWO_SECOND, PROX_IN_AXIS_TWO_FIRST,
                ENCODER_PORT_AXIS_TWO.b, ENCODER_PORT_AXIS_TWO.a,
                PROX_IN_AXIS_ONE_SECOND, PROX_IN_AXIS_ONE_FIRST,
                ENCODER_PORT_AXIS_ONE.b, ENCODER_PORT_AXIS_ONE.a};
  assign rise = sig & ~st.prev;
  assign tick = st.tick_cnt == 16'(TICK_CYC - 1);
  assign gate_end = tick && (st.gate_cnt == 10'(GATE_TICKS - 1));
  assign addr_ok = HSEL && HREADY && HTRANS[1];

  // The slave never stalls and never errors.
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign HRDATA = st.rdata;
  assign AXIS_ONE_STATUS = st.out[0];
  assign AXIS_TWO_STATUS = st.out[1];

  // Read multiplexer, sampled in the address phase so data come from a flop.
  function automatic logic [31:0] rd_word(input dasm_state_t s, input logic [31:0] a);
    logic [31:0] w;
    w = 32'h0000_0000;
    if (a[31:8] == 24'h00_0000) begin
      case (a[7:0])
        ADDR_CFG0: w = s.cfg[0];
        ADDR_CFG1: w = s.cfg[1];
        ADDR_STAND0: w = {16'h0000, s.stand[0]};
        ADDR_STAND1: w = {16'h0000, s.stand[1]};
        ADDR_STATUS: w = {16'h0000, 3'h0, s.out[1], 3'h0, s.out[0]};
        default: begin
          // Tables; any other address reads as zero.
          if (a[7:5] == PAGE_SPEED) begin
            w = {16'h0000, s.speed[a[4:2]]};
          end else if (a[7:5] == PAGE_FREQ) begin
            w = {16'h0000, s.freq[a[4:2]]};
          end
        end
      endcase
    end
    return w;
  endfunction

  // Per-axis evaluation of the measured rates.
  for (genvar i = 0; i < NAX; i++) begin : g_axis
    logic [NSIG-1:0] lo;  // Below the standstill frequency.
    logic [NSIG-1:0] hi2; // Above standstill and above the mismatch floor.
    logic [NSIG-1:0] os;  // Above the selected speed limit.
    logic [15:0]     lim; // Selected speed limit.
    logic            enc; // Encoder only.
    logic            prx; // Two switches.
    logic            cmb; // Encoder with one switch.
    logic            ab_d; // Track A and B disagree.
    logic            pp_d; // Switches disagree.

    // Compare each signal on its own against all three thresholds.
    always_comb begin
      lim = st.speed[st.cfg[i].speed_sel];
      for (int k = 0; k < NSIG; k++) begin
        lo[k] = st.freq[i*NSIG+k] < st.stand[i];
        hi2[k] = !lo[k] && (st.freq[i*NSIG+k] > DIFF_MIN_HZ);
        os[k] = st.freq[i*NSIG+k] > lim;
      end
    end

    assign enc = st.cfg[i].in_type == IN_ENC;
    assign prx = st.cfg[i].in_type == IN_PROX;
    assign cmb = st.cfg[i].in_type == IN_COMBO;
    assign ab_d = (lo[SIG_A] != lo[SIG_B]) && (hi2[SIG_A] || hi2[SIG_B]);
    assign pp_d = (lo[SIG_P1] != lo[SIG_P2]) && (hi2[SIG_P1] || hi2[SIG_P2]);

    // A combined axis votes two of three and never reads the second switch.
    assign still_c[i] = enc ? (lo[SIG_A] && lo[SIG_B]) :
                        prx ? (lo[SIG_P1] && lo[SIG_P2]) :
                        cmb ? ((lo[SIG_A] && lo[SIG_B]) || (lo[SIG_A] && lo[SIG_P1]) ||
                               (lo[SIG_B] && lo[SIG_P1])) : 1'b0;

    // Fast switch with both tracks still means the shaft has parted.
    assign shear_c[i] = cmb && st.cfg[i].shear_en && lo[SIG_A] && lo[SIG_B] &&
                        !lo[SIG_P1];

    // An unknown arrangement is treated as a fault so it can never look healthy.
    assign diff_c[i] = ((enc || cmb) && ab_d) || (prx && pp_d) ||
                       !(enc || prx || cmb);

    assign ovs_c[i] = enc ? (os[SIG_A] || os[SIG_B]) :
                      prx ? (os[SIG_P1] || os[SIG_P2]) :
                      (os[SIG_A] || os[SIG_B] || os[SIG_P1]);
    assign safe_c[i] = shear_c[i] || diff_c[i];

    // Overspeed that has not yet served its delay.
    sequence ovs_wait_s;
      ovs_c[i] && !safe_c[i] && (st.ovs_cnt[i] < st.cfg[i].delay);
    endsequence

    // Overspeed that has served its delay.
    sequence ovs_done_s;
      ovs_c[i] && (st.ovs_cnt[i] >= st.cfg[i].delay);
    endsequence

    shear_flag_a: assert property (shear_c[i] |=> st.out[i].shear)
      else $error("shearpin break not flagged");
    shear_safe_a: assert property (st.out[i].shear |-> !st.out[i].speed_ok &&
                                   !st.out[i].standstill)
      else $error("shearpin break left outputs live");
    auto_release_a: assert property (!safe_c[i] && !ovs_c[i] |=> st.out[i].speed_ok)
      else $error("safe state not released");
    combo_vote_a: assert property (cmb && !safe_c[i] && (lo[SIG_A] + lo[SIG_B] +
                                   lo[SIG_P1] >= 2) |=> st.out[i].standstill)
      else $error("two of three vote lost");
    pair_diff_a: assert property (diff_c[i] |=> st.out[i].fault && !st.out[i].speed_ok)
      else $error("mismatch did not force safe state");
    ovs_hold_a: assert property (ovs_wait_s |=> st.out[i].speed_ok)
      else $error("overspeed tripped before its delay");
    ovs_trip_a: assert property (ovs_done_s |=> !st.out[i].speed_ok)
      else $error("overspeed not tripped after its delay");
    dir_phase_a: assert property (rise[i*NSIG+SIG_A] |=>
                                  st.out[i].dir == !$past(sig[i*NSIG+SIG_B]))
      else $error("direction does not follow phase order");
  end

  // Next-state logic for measurement, results and the register slave.
  always_comb begin
    nx = st;
    nx.wr_pend = 1'b0;

    // Time base divider and gate window counter.
    nx.tick_cnt = tick ? 16'h0000 : st.tick_cnt + 16'h0001;
    if (gate_end) begin
      nx.gate_cnt = 10'h000;
    end else if (tick) begin
      nx.gate_cnt = st.gate_cnt + 10'h001;
    end

    // Count rising edges per input; a full gate gives the rate in Hz.
    nx.prev = sig;
    for (int s = 0; s < NAX*NSIG; s++) begin
      if (gate_end) begin
        nx.freq[s] = st.edges[s];
        nx.edges[s] = {15'h0000, rise[s]};
      end else if (rise[s] && (st.edges[s] != 16'hFFFF)) begin
        // Saturate rather than wrap, so a very fast input still reads fast.
        nx.edges[s] = st.edges[s] + 16'h0001;
      end
    end

    // Results per axis; all but the direction are rebuilt every cycle, so a fault clears itself.
    for (int i = 0; i < NAX; i++) begin
      // A rising edge of A with B low counts as forward.
      if (rise[i*NSIG+SIG_A]) begin
        nx.out[i].dir = !sig[i*NSIG+SIG_B];
      end
      // Delay counter restarts whenever the overspeed goes away.
      if (!ovs_c[i]) begin
        nx.ovs_cnt[i] = 16'h0000;
      end else if (tick && (st.ovs_cnt[i] < st.cfg[i].delay)) begin
        nx.ovs_cnt[i] = st.ovs_cnt[i] + 16'h0001;
      end
      nx.out[i].shear = shear_c[i];
      nx.out[i].fault = diff_c[i];
      nx.out[i].standstill = still_c[i] && !safe_c[i];
      nx.out[i].speed_ok = !safe_c[i] &&
                           !(ovs_c[i] && (st.ovs_cnt[i] >= st.cfg[i].delay));
    end

    // Data phase of a write: store into the decoded register.
    if (st.wr_pend) begin
      case (st.wr_addr)
        ADDR_CFG0: nx.cfg[0] = HWDATA;
        ADDR_CFG1: nx.cfg[1] = HWDATA;
        ADDR_STAND0: nx.stand[0] = HWDATA[15:0];
        ADDR_STAND1: nx.stand[1] = HWDATA[15:0];
        default: begin
          // Speed table; status and rates are read only.
          if (st.wr_addr[7:5] == PAGE_SPEED) begin
            nx.speed[st.wr_addr[4:2]] = HWDATA[15:0];
          end
        end
      endcase
    end

    // Address phase: latch writes and fetch read data.
    if (addr_ok) begin
      // Writes above the map are dropped by clearing the pending flag.
      nx.wr_pend = HWRITE && (HADDR[31:8] == 24'h00_0000);
      nx.wr_addr = HADDR[7:0];
      nx.rdata = rd_word(st, HADDR);
    end
  end

  // State register with synchronous reset; results start in the safe state.
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      st <= '0;
      st.cfg <= {NAX{CFG_RST}};
      st.stand <= {NAX{STAND_RST}};
      st.speed <= {NSPD{SPEED_RST}};
    end else begin
      st <= nx;
    end
  end

  // A configuration write: address phase then its data phase.
  sequence cfg0_wr_s;
    addr_ok && HWRITE && (HADDR == {24'h00_0000, ADDR_CFG0}) ##1 1'b1;
  endsequence

  cfg_write_a: assert property (cfg0_wr_s |=> st.cfg[0] == $past(HWDATA))
    else $error("configuration write not stored");
  gate_meas_a: assert property (gate_end |=> st.freq == $past(st.edges))
    else $error("gate count not transferred to rate");
  still_mark_a: assert property (!still_c[0] |=> !st.out[0].standstill)
    else $error("axis one standstill without cause");
endmodule

// File: include/dasm_pkg.sv
// Constants and carrier types of the dual axis standstill monitor.
// Assumes one 20 MHz core clock and word-wide AHB-Lite register access.
package dasm_pkg;
  // Core clock, time base tick and measurement gate.
  localparam int unsigned CLK_HZ     = 20_000_000; // Core clock rate in Hz.
  localparam int unsigned TICK_US    = 1000;       // Tick period in microseconds.
  localparam int unsigned TICK_CYC   = CLK_HZ / 1_000_000 * TICK_US; // Cycles per tick.
  localparam int unsigned GATE_TICKS = 1000;       // Ticks per gate, so counts read in Hz.
  localparam logic [15:0] DIFF_MIN_HZ = 16'h0002;  // A track mismatch counts only above this frequency.
  // Geometry.
  localparam int NAX  = 2; // Monitored axes.
  localparam int NSIG = 4; // Signals per axis.
  localparam int NSPD = 8; // Selectable speed limits.
  localparam int SIG_A  = 0; // Encoder track A.
  localparam int SIG_B  = 1; // Encoder track B.
  localparam int SIG_P1 = 2; // First proximity input.
  localparam int SIG_P2 = 3; // Second proximity input.
  // Input arrangement codes.
  localparam logic [1:0] IN_ENC   = 2'h0; // One encoder.
  localparam logic [1:0] IN_PROX  = 2'h1; // Two proximity switches.
  localparam logic [1:0] IN_COMBO = 2'h2; // Encoder plus one switch.
  // Register byte offsets and table pages.
  localparam logic [7:0] ADDR_CFG0   = 8'h00;
  localparam logic [7:0] ADDR_CFG1   = 8'h04;
  localparam logic [7:0] ADDR_STAND0 = 8'h08;
  localparam logic [7:0] ADDR_STAND1 = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [2:0] PAGE_SPEED  = 3'h1; // Speed limits at 0x20 to 0x3C.
  localparam logic [2:0] PAGE_FREQ   = 3'h2; // Measured rates at 0x40 to 0x5C.
  // Reset values.
  localparam logic [31:0] CFG_RST   = 32'h0000_0000;
  localparam logic [15:0] STAND_RST = 16'h0001;
  localparam logic [15:0] SPEED_RST = 16'h0064;
  // Per-axis configuration word.
  typedef struct packed {
    logic [15:0] delay;     // Overspeed switch-off delay in ticks.
    logic [7:0]  rsv;       // Reads back as written.
    logic [2:0]  speed_sel; // Selected speed limit.
    logic        rst_mode;  // Reset mode, held for the base unit.
    logic        ax_type;   // Axis type, held for the base unit.
    logic        shear_en;  // Broken shearpin check enable.
    logic [1:0]  in_type;   // Input arrangement.
  } dasm_cfg_t;
  // Encoder connector tracks.
  typedef struct packed {
    logic b;
    logic a;
  } dasm_enc_t;
  // Per-axis result to the base unit.
  typedef struct packed {
    logic shear;
    logic fault;
    logic dir;
    logic speed_ok;
    logic standstill;
  } dasm_axis_t;
  // Whole state of the monitor.
  typedef struct packed {
    logic [15:0]                tick_cnt;
    logic [9:0]                 gate_cnt;
    logic [NAX*NSIG-1:0][15:0]  edges;
    logic [NAX*NSIG-1:0][15:0]  freq;
    logic [NAX*NSIG-1:0]        prev;
    dasm_cfg_t [NAX-1:0]        cfg;
    logic [NAX-1:0][15:0]       stand;
    logic [NSPD-1:0][15:0]      speed;
    logic [NAX-1:0][15:0]       ovs_cnt;
    dasm_axis_t [NAX-1:0]       out;
    logic                       wr_pend;
    logic [7:0]                 wr_addr;
    logic [31:0]                rdata;
  } dasm_state_t;
endpackage

// File: tb/dasm_pulse_src.sv
// Pulse source for one axis: a quadrature encoder and two proximity switches.
// Assumes it runs on the core clock; quarter length zero freezes every line.
`timescale 1ns/100ps
module dasm_pulse_src
  import dasm_pkg::*;
(
  input  wire logic [7:0] q,    // Cycles per quarter period, zero stops.
  input  wire logic [4:0] ctl,  // Enables {p2, p1, rev, b, a}.
  input  wire logic       clk,
  output dasm_enc_t       enc,
  output logic            p1,
  output logic            p2
);
  logic [7:0] cnt = 8'h00; // Cycle count inside a quarter.
  logic [1:0] ph  = 2'h0;  // Quarter index of the period.
  logic       fa;          // Leading track shape.
  logic       fb;          // Lagging track shape.

  // Step the phase; a stopped source keeps its levels, as a still shaft does.
  always_ff @(posedge clk) begin
    if (q == 8'h00) begin
      cnt <= 8'h00;
    end else if (cnt >= q - 8'h01) begin
      cnt <= 8'h00;
      ph  <= ph + 2'h1;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end

  // Reverse swaps which track leads; switches pulse once per period.
  assign fa    = (ph == 2'h1) || (ph == 2'h2);
  assign fb    = (ph == 2'h2) || (ph == 2'h3);
  assign enc.a = ctl[0] & (ctl[2] ? fb : fa);
  assign enc.b = ctl[1] & (ctl[2] ? fa : fb);
  assign p1    = ctl[3] & ph[1];
  assign p2    = ctl[4] & ph[1];
endmodule

// File: tb/tb_dual_axis_standstill_monitor.sv
// Self-checking bench for the monitor: AHB-Lite tasks and pulse sources.
// Assumes TICK_CYC of 4, so one gate is 4000 cycles and rates read in Hz.
`timescale 1ns/100ps
module tb_dual_axis_standstill_monitor;
  import dasm_pkg::*;
  logic        core_clk = 1'b0;     // 20 MHz clock.
  logic        rst      = 1'b1;     // Synchronous reset.
  logic        hsel     = 1'b0;     // Bus select.
  logic [1:0]  htrans   = 2'h0;     // Transfer type.
  logic        hwrite   = 1'b0;     // Direction.
  logic [31:0] haddr    = 32'h0;    // Address.
  logic [31:0] hwdata   = 32'h0;    // Write data.
  logic        hreadyout;           // Slave ready, also bus ready.
  logic        hresp;               // Response, checked as okay on reads.
  logic [31:0] hrdata;              // Read data.
  logic [7:0]  q1       = 8'h00;    // Axis one quarter length.
  logic [7:0]  q2       = 8'h00;    // Axis two quarter length.
  logic [4:0]  c1       = 5'h00;    // Axis one enables.
  logic [4:0]  c2       = 5'h00;    // Axis two enables.
  dasm_enc_t   enc1;                // Axis one tracks.
  dasm_enc_t   enc2;                // Axis two tracks.
  logic        p11, p12, p21, p22;  // Switch lines.
  dasm_axis_t  st1;                 // Axis one status.
  dasm_axis_t  st2;                 // Axis two status.
  int          n_mismatch  = 0;     // Failed comparisons.
  int          check_count = 0;     // All comparisons.
  int          cyc         = 0;     // Cycles since start.

  // Half period of 25 ns.
  always #25 core_clk = ~core_clk;

  dasm_pulse_src u_src1 (.q(q1), .ctl(c1), .clk(core_clk), .enc(enc1), .p1(p11), .p2(p12));
  dasm_pulse_src u_src2 (.q(q2), .ctl(c2), .clk(core_clk), .enc(enc2), .p1(p21), .p2(p22));

  dasm_monitor #(.TICK_CYC(4)) u_dut (
    .CORE_CLK(core_clk), .RST(rst),
    .ENCODER_PORT_AXIS_ONE(enc1), .ENCODER_PORT_AXIS_TWO(enc2),
    .PROX_IN_AXIS_ONE_FIRST(p11), .PROX_IN_AXIS_ONE_SECOND(p12),
    .PROX_IN_AXIS_TWO_FIRST(p21), .PROX_IN_AXIS_TWO_SECOND(p22),
    .AXIS_ONE_STATUS(st1), .AXIS_TWO_STATUS(st2),
    .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2),
    .HWDATA(hwdata), .HREADY(hreadyout), .HREADYOUT(hreadyout), .HRESP(hresp),
    .HRDATA(hrdata)
  );

  // Prints the verdict and stops the run.
  task automatic wrap_up;
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Counts one comparison and reports a difference at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // One single transfer; the master waits on ready, however long it takes.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd);
    @(posedge core_clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= {24'h0, a};
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  // Register write.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  // Register read against an expected word.
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string w);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    chk(x, e, w);
    chk({31'h0, hresp}, 32'h0, "response okay");
  endtask

  // Both status words under a mask, sampled away from the clock edge.
  task automatic st(input logic [4:0] e1, input logic [4:0] e2, input logic [4:0] m,
                    input string w);
    @(negedge core_clk);
    chk({27'h0, st1 & m}, {27'h0, e1 & m}, w);
    chk({27'h0, st2 & m}, {27'h0, e2 & m}, w);
    // Return on a rising edge so that the next stimulus lands on it.
    @(posedge core_clk);
  endtask

  // A hang ends the run as a failure.
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 65000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  initial begin
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    st(5'h00, 5'h00, 5'h1F, "reset safe");
    rd(ADDR_CFG0, 32'h0000_0000, "cfg0 reset");
    rd(ADDR_STAND0, 32'h0000_0001, "stand reset");
    rd(8'h3C, 32'h0000_0064, "speed7 reset");
    wr(8'h80, 32'hFFFF_FFFF);
    rd(8'h80, 32'h0000_0000, "unmapped");
    // Axis two combined with shearpin check; everything at rest.
    wr(ADDR_CFG1, 32'h0000_0006);
    rd(ADDR_CFG1, 32'h0000_0006, "cfg1");
    repeat (8000) @(posedge core_clk);
    st(5'h03, 5'h03, 5'h1B, "rest");
    // Axis one forward at 100 Hz; axis two switch only, tracks still.
    wr(ADDR_CFG0, 32'h09C4_0000);
    q1 <= 8'h0A;
    c1 <= 5'h03;
    q2 <= 8'h0A;
    c2 <= 5'h08;
    repeat (8000) @(posedge core_clk);
    st(5'h06, 5'h10, 5'h1F, "run and shear");
    rd(8'h40, 32'h0000_0064, "rate a1");
    rd(8'h58, 32'h0000_0064, "rate p1 axis2");
    rd(ADDR_STATUS, 32'h0000_1006, "status word");
    // Axis one reverse at 200 Hz with a 2500 tick delay; axis two tracks run.
    q1 <= 8'h05;
    c1 <= 5'h07;
    c2 <= 5'h03;
    repeat (8000) @(posedge core_clk);
    st(5'h02, 5'h06, 5'h1F, "delay hold");
    repeat (10100) @(posedge core_clk);
    st(5'h00, 5'h06, 5'h1F, "delay trip");
    // Second speed limit of 300 Hz lifts the overspeed.
    wr(8'h24, 32'h0000_012C);
    wr(ADDR_CFG0, 32'h09C4_0020);
    rd(8'h24, 32'h0000_012C, "speed1");
    st(5'h02, 5'h06, 5'h1F, "speed select");
    // Track B lost on axis one.
    c1 <= 5'h05;
    repeat (8000) @(posedge core_clk);
    st(5'h08, 5'h06, 5'h1B, "track mismatch");
    // Track B back; axis two becomes a switch pair.
    wr(ADDR_CFG1, 32'h0000_0001);
    c1 <= 5'h07;
    c2 <= 5'h18;
    repeat (8000) @(posedge core_clk);
    st(5'h02, 5'h02, 5'h1B, "release and pair");
    wrap_up();
  end
endmodule
